// ==== rtl/cldm_pkg.sv ====
// constants for the closed-loop deviation monitor
package cldm_pkg;
    localparam int unsigned AW = 8;
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_EPPR  = 8'h04;
    localparam logic [7:0] OFS_LIMIT = 8'h08;
    localparam logic [7:0] OFS_CREV  = 8'h0c;
    localparam logic [7:0] OFS_IPPR  = 8'h10;
    localparam logic [7:0] OFS_INUM  = 8'h14;
    localparam logic [7:0] OFS_IDEN  = 8'h18;
    localparam logic [7:0] OFS_ONUM  = 8'h1c;
    localparam logic [7:0] OFS_ODEN  = 8'h20;
    localparam logic [7:0] OFS_FWD   = 8'h24;
    localparam logic [7:0] OFS_REV   = 8'h28;
    localparam logic [7:0] OFS_ICNT  = 8'h2c;
    localparam logic [7:0] OFS_ECNT  = 8'h30;
    localparam logic [7:0] OFS_DEV   = 8'h34;
    localparam logic [7:0] OFS_STAT  = 8'h38;
    // control register fields
    localparam int unsigned C_MODE  = 0;
    localparam int unsigned C_INV   = 2;
    localparam int unsigned C_ZHIDE = 3;
    localparam int unsigned C_ZSRC  = 4;
    localparam int unsigned C_SOFT  = 5;
    localparam int unsigned C_DIV   = 8;
    localparam int unsigned C_FILT  = 12;
    localparam int unsigned C_CLR   = 16;
    // synchronised pin vector positions
    localparam int unsigned P_EB = 0;
    localparam int unsigned P_EA = 1;
    localparam int unsigned P_IB = 2;
    localparam int unsigned P_IA = 3;
    localparam int unsigned P_EZ = 4;
    localparam int unsigned P_IZ = 5;
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
    localparam logic [31:0] RST_EPPR  = 32'h0000_1000;
    localparam logic [31:0] RST_LIMIT = 32'h0000_2710;
    localparam logic [31:0] RST_CREV  = 32'h0000_000a;
    localparam logic [31:0] RST_IPPR  = 32'h0000_1000;
    localparam logic [31:0] RST_GEAR  = 32'h0000_0001;
    localparam logic [31:0] RST_FWD   = 32'h7fff_ffff;
    localparam logic [31:0] RST_REV   = 32'h8000_0000;
    // internal steps with no external change before the loop fault
    localparam logic [15:0] STALL_STEPS = 16'h0400;
    localparam logic [1:0] MODE_GEAR2 = 2'h2;
    localparam logic [1:0] SOFT_NOW   = 2'h1;
    localparam logic [1:0] SOFT_HOMED = 2'h2;
    localparam logic [1:0] DIV_INHIB  = 2'h2;
endpackage : cldm_pkg

// ==== rtl/cldm_top.sv ====
// closed-loop deviation monitor with apb register file
`timescale 1ns/100ps
`default_nettype none
module cldm_top (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        int_a,
    input  wire logic        int_b,
    input  wire logic        int_z,
    input  wire logic        ext_a,
    input  wire logic        ext_b,
    input  wire logic        ext_z,
    input  wire logic        homing_done,
    output logic             probe_z,
    output logic             div_out_inhibit,
    output logic             deviation_excess_fault,
    output logic             closed_loop_fault,
    output logic             forward_overtravel_warning,
    output logic             reverse_overtravel_warning,
    output logic             soft_stop
);
    logic [5:0]  s1_r, s2_r, s3_r;
    logic [31:0] ctrl_r, ctrl_nxt, eppr_r, eppr_nxt, lim_r, lim_nxt, crev_r, crev_nxt;
    logic [31:0] ippr_r, ippr_nxt, inum_r, inum_nxt, iden_r, iden_nxt;
    logic [31:0] onum_r, onum_nxt, oden_r, oden_nxt, fwd_r, fwd_nxt, rev_r, rev_nxt;
    logic [31:0] icnt_r, icnt_nxt, ecnt_r, ecnt_nxt, mpos_r, mpos_nxt;
    logic [31:0] acc_r, acc_nxt, filt_r, filt_nxt, rp_r, rp_nxt, revs_r, revs_nxt;
    logic [31:0] prdata_nxt, num, den, dev, mag;
    logic [15:0] stall_r, stall_nxt;
    logic        pready_nxt, pslverr_nxt, homed_r, homed_nxt;
    logic        dfault_r, dfault_nxt, cfault_r, cfault_nxt, fw_r, fw_nxt, rw_r, rw_nxt;
    logic        stop_r, stop_nxt, pz_r, pz_nxt, div_r, div_nxt;
    logic        istep, iup, estep, eup, wr, clr, armed, clr_evt, rev_evt;
    logic [1:0]  mode, smode;
    logic        pready_r, pslverr_r;
    logic [31:0] prdata_r;

    assign pready                     = pready_r;
    assign prdata                     = prdata_r;
    assign pslverr                    = pslverr_r;
    assign probe_z                    = pz_r;
    assign div_out_inhibit            = div_r;
    assign deviation_excess_fault     = dfault_r;
    assign closed_loop_fault          = cfault_r;
    assign forward_overtravel_warning = fw_r;
    assign reverse_overtravel_warning = rw_r;
    assign soft_stop                  = stop_r;

    always_comb begin
        mode  = ctrl_r[cldm_pkg::C_MODE +: 2];
        smode = ctrl_r[cldm_pkg::C_SOFT +: 2];
        // quadrature: one edge per cycle, direction from previous a and current b
        istep = (s2_r[cldm_pkg::P_IA] ^ s3_r[cldm_pkg::P_IA])
              ^ (s2_r[cldm_pkg::P_IB] ^ s3_r[cldm_pkg::P_IB]);
        iup   = s3_r[cldm_pkg::P_IA] ^ s2_r[cldm_pkg::P_IB];
        estep = (s2_r[cldm_pkg::P_EA] ^ s3_r[cldm_pkg::P_EA])
              ^ (s2_r[cldm_pkg::P_EB] ^ s3_r[cldm_pkg::P_EB]);
        eup   = (s3_r[cldm_pkg::P_EA] ^ s2_r[cldm_pkg::P_EB]) ^ ctrl_r[cldm_pkg::C_INV];
        num   = (mode == cldm_pkg::MODE_GEAR2) ? onum_r : inum_r;
        den   = (mode == cldm_pkg::MODE_GEAR2) ? oden_r : iden_r;
        dev   = mpos_r - ecnt_r;
        mag   = filt_r[31] ? 32'h0 - filt_r : filt_r;
        wr    = psel & penable & pready_r & pwrite;
        clr   = wr && paddr == cldm_pkg::OFS_CTRL && pwdata[cldm_pkg::C_CLR];
        pready_nxt  = psel & penable & ~pready_r;
        pslverr_nxt = 1'b0;
        prdata_nxt  = 32'h0;
        ctrl_nxt = ctrl_r;
        eppr_nxt = eppr_r;
        lim_nxt  = lim_r;
        crev_nxt = crev_r;
        ippr_nxt = ippr_r;
        inum_nxt = inum_r;
        iden_nxt = iden_r;
        onum_nxt = onum_r;
        oden_nxt = oden_r;
        fwd_nxt  = fwd_r;
        rev_nxt  = rev_r;
        if (pready_nxt) begin
            case (paddr)
                cldm_pkg::OFS_CTRL:  prdata_nxt = {16'h0, ctrl_r[15:0]};
                cldm_pkg::OFS_EPPR:  prdata_nxt = eppr_r;
                cldm_pkg::OFS_LIMIT: prdata_nxt = lim_r;
                cldm_pkg::OFS_CREV:  prdata_nxt = crev_r;
                cldm_pkg::OFS_IPPR:  prdata_nxt = ippr_r;
                cldm_pkg::OFS_INUM:  prdata_nxt = inum_r;
                cldm_pkg::OFS_IDEN:  prdata_nxt = iden_r;
                cldm_pkg::OFS_ONUM:  prdata_nxt = onum_r;
                cldm_pkg::OFS_ODEN:  prdata_nxt = oden_r;
                cldm_pkg::OFS_FWD:   prdata_nxt = fwd_r;
                cldm_pkg::OFS_REV:   prdata_nxt = rev_r;
                cldm_pkg::OFS_ICNT:  prdata_nxt = icnt_r;
                cldm_pkg::OFS_ECNT:  prdata_nxt = ecnt_r;
                cldm_pkg::OFS_DEV:   prdata_nxt = filt_r;
                cldm_pkg::OFS_STAT:  prdata_nxt = {26'h0, homed_r, stop_r, rw_r, fw_r,
                                                   cfault_r, dfault_r};
                default:             pslverr_nxt = 1'b1;
            endcase
        end
        if (wr) begin
            case (paddr)
                cldm_pkg::OFS_CTRL:  ctrl_nxt = {16'h0, pwdata[15:0]};
                cldm_pkg::OFS_EPPR:  eppr_nxt = pwdata;
                cldm_pkg::OFS_LIMIT: lim_nxt  = pwdata;
                cldm_pkg::OFS_CREV:  crev_nxt = pwdata;
                cldm_pkg::OFS_IPPR:  ippr_nxt = pwdata;
                cldm_pkg::OFS_INUM:  inum_nxt = pwdata;
                cldm_pkg::OFS_IDEN:  iden_nxt = pwdata;
                cldm_pkg::OFS_ONUM:  onum_nxt = pwdata;
                cldm_pkg::OFS_ODEN:  oden_nxt = pwdata;
                cldm_pkg::OFS_FWD:   fwd_nxt  = pwdata;
                cldm_pkg::OFS_REV:   rev_nxt  = pwdata;
                default:             ctrl_nxt = ctrl_r;
            endcase
        end
        // counters and motor-side position through the gear
        icnt_nxt = istep ? (iup ? icnt_r + 32'h1 : icnt_r - 32'h1) : icnt_r;
        ecnt_nxt = estep ? (eup ? ecnt_r + 32'h1 : ecnt_r - 32'h1) : ecnt_r;
        acc_nxt  = istep ? (iup ? acc_r + num : acc_r - num) : acc_r;
        mpos_nxt = mpos_r;
        if (den != 32'h0 && $signed(acc_nxt) >= $signed(den)) begin
            acc_nxt  = acc_nxt - den;
            mpos_nxt = mpos_r + 32'h1;
        end else if (den != 32'h0 && $signed(acc_nxt) <= -$signed(den)) begin
            acc_nxt  = acc_nxt + den;
            mpos_nxt = mpos_r - 32'h1;
        end
        filt_nxt = filt_r + 32'($signed(dev - filt_r) >>> ctrl_r[cldm_pkg::C_FILT +: 4]);
        // revolution count from internal pulses
        rp_nxt   = istep ? rp_r + 32'h1 : rp_r;
        revs_nxt = revs_r;
        rev_evt  = istep && ippr_r != 32'h0 && rp_nxt >= ippr_r;
        if (rev_evt) begin
            rp_nxt   = 32'h0;
            revs_nxt = revs_r + 32'h1;
        end
        clr_evt = rev_evt && crev_r != 32'h0 && revs_nxt >= crev_r && !dfault_r;
        if (clr_evt) begin
            revs_nxt = 32'h0;
            mpos_nxt = ecnt_nxt;
            acc_nxt  = 32'h0;
            filt_nxt = 32'h0;
        end
        if (mode == 2'h0) begin
            mpos_nxt = ecnt_nxt;
            filt_nxt = 32'h0;
        end
        // faults: set wins over a software clear
        dfault_nxt = (dfault_r & ~clr) | (mode != 2'h0 && lim_r != 32'h0 && mag > lim_r);
        stall_nxt  = (estep || mode == 2'h0) ? 16'h0 : (istep ? stall_r + 16'h1 : stall_r);
        cfault_nxt = (cfault_r & ~clr) | (stall_r >= cldm_pkg::STALL_STEPS);
        // homing z source and divider inhibit
        pz_nxt  = ctrl_r[cldm_pkg::C_ZSRC]
                ? (s2_r[cldm_pkg::P_EZ] & ~ctrl_r[cldm_pkg::C_ZHIDE])
                : s2_r[cldm_pkg::P_IZ];
        div_nxt = ctrl_r[cldm_pkg::C_DIV +: 2] == cldm_pkg::DIV_INHIB;
        // software limit on the internal position
        homed_nxt = homed_r | homing_done;
        armed  = smode == cldm_pkg::SOFT_NOW
              || (smode == cldm_pkg::SOFT_HOMED && homed_r);
        fw_nxt = armed && $signed(icnt_r) > $signed(fwd_r);
        rw_nxt = armed && $signed(icnt_r) < $signed(rev_r);
        stop_nxt = fw_nxt | rw_nxt;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_r      <= 6'h0;
            s2_r      <= 6'h0;
            s3_r      <= 6'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
            ctrl_r    <= cldm_pkg::RST_CTRL;
            eppr_r    <= cldm_pkg::RST_EPPR;
            lim_r     <= cldm_pkg::RST_LIMIT;
            crev_r    <= cldm_pkg::RST_CREV;
            ippr_r    <= cldm_pkg::RST_IPPR;
            inum_r    <= cldm_pkg::RST_GEAR;
            iden_r    <= cldm_pkg::RST_GEAR;
            onum_r    <= cldm_pkg::RST_GEAR;
            oden_r    <= cldm_pkg::RST_GEAR;
            fwd_r     <= cldm_pkg::RST_FWD;
            rev_r     <= cldm_pkg::RST_REV;
            icnt_r    <= 32'h0;
            ecnt_r    <= 32'h0;
            mpos_r    <= 32'h0;
            acc_r     <= 32'h0;
            filt_r    <= 32'h0;
            rp_r      <= 32'h0;
            revs_r    <= 32'h0;
            stall_r   <= 16'h0;
            homed_r   <= 1'b0;
            dfault_r  <= 1'b0;
            cfault_r  <= 1'b0;
            fw_r      <= 1'b0;
            rw_r      <= 1'b0;
            stop_r    <= 1'b0;
            pz_r      <= 1'b0;
            div_r     <= 1'b0;
        end else begin
            s1_r      <= {int_z, ext_z, int_a, int_b, ext_a, ext_b};
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            ctrl_r    <= ctrl_nxt;
            eppr_r    <= eppr_nxt;
            lim_r     <= lim_nxt;
            crev_r    <= crev_nxt;
            ippr_r    <= ippr_nxt;
            inum_r    <= inum_nxt;
            iden_r    <= iden_nxt;
            onum_r    <= onum_nxt;
            oden_r    <= oden_nxt;
            fwd_r     <= fwd_nxt;
            rev_r     <= rev_nxt;
            icnt_r    <= icnt_nxt;
            ecnt_r    <= ecnt_nxt;
            mpos_r    <= mpos_nxt;
            acc_r     <= acc_nxt;
            filt_r    <= filt_nxt;
            rp_r      <= rp_nxt;
            revs_r    <= revs_nxt;
            stall_r   <= stall_nxt;
            homed_r   <= homed_nxt;
            dfault_r  <= dfault_nxt;
            cfault_r  <= cfault_nxt;
            fw_r      <= fw_nxt;
            rw_r      <= rw_nxt;
            stop_r    <= stop_nxt;
            pz_r      <= pz_nxt;
            div_r     <= div_nxt;
        end
    end

    sequence s_eup;
        estep && eup;
    endsequence
    property p_ext_count;
        @(posedge clock) disable iff (rst) s_eup |=> ecnt_r == $past(ecnt_r) + 32'h1;
    endproperty
    a_ext_count: assert property (p_ext_count)
        else $error("external count not incremented");
    property p_dev_set;
        @(posedge clock) disable iff (rst)
            (mode != 2'h0 && lim_r != 32'h0 && mag > lim_r) |=> dfault_r [*2];
    endproperty
    a_dev_set: assert property (p_dev_set)
        else $error("deviation fault missing");
    property p_dev_off;
        @(posedge clock) disable iff (rst) (lim_r == 32'h0 && !dfault_r) |=> !dfault_r;
    endproperty
    a_dev_off: assert property (p_dev_off)
        else $error("fault with zero limit");
    property p_no_clear;
        @(posedge clock) disable iff (rst) crev_r == 32'h0 |-> !clr_evt;
    endproperty
    a_no_clear: assert property (p_no_clear)
        else $error("clear with zero revolutions");
    property p_zhide;
        @(posedge clock) disable iff (rst)
            (ctrl_r[cldm_pkg::C_ZSRC] && ctrl_r[cldm_pkg::C_ZHIDE]) |=> !probe_z;
    endproperty
    a_zhide: assert property (p_zhide)
        else $error("hidden external z passed");
    property p_div;
        @(posedge clock) disable iff (rst)
            ctrl_r[cldm_pkg::C_DIV +: 2] == cldm_pkg::DIV_INHIB |=> div_out_inhibit;
    endproperty
    a_div: assert property (p_div)
        else $error("divider not inhibited");
    property p_stall;
        @(posedge clock) disable iff (rst) stall_r >= cldm_pkg::STALL_STEPS |=> closed_loop_fault;
    endproperty
    a_stall: assert property (p_stall)
        else $error("loop fault missing");
    property p_soft_homed;
        @(posedge clock) disable iff (rst)
            (smode == cldm_pkg::SOFT_HOMED && !homed_r) |=> !fw_r && !rw_r;
    endproperty
    a_soft_homed: assert property (p_soft_homed)
        else $error("limit armed before homing");
    property p_soft_off;
        @(posedge clock) disable iff (rst) smode == 2'h0 |=> !soft_stop;
    endproperty
    a_soft_off: assert property (p_soft_off)
        else $error("stop while limit off");
    property p_fwd;
        @(posedge clock) disable iff (rst)
            (armed && $signed(icnt_r) > $signed(fwd_r)) |=> fw_r && soft_stop;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward warning missing");
endmodule : cldm_top
`default_nettype wire

// ==== bench/cldm_enc.sv ====
// behavioural quadrature encoder model for the motor and the external scale
`timescale 1ns/100ps
`default_nettype none
module cldm_enc (
    input  wire logic clock,
    output logic      a,
    output logic      b,
    output logic      z
);
    logic [1:0] s;

    initial begin
        s = 2'h0;
        a = 1'b0;
        b = 1'b0;
        z = 1'b0;
    end

    // one gray step, level held four cycles so the receiver never sees a/b move together
    task step(input logic up);
        @(posedge clock);
        s = up ? s + 2'h1 : s - 2'h1;
        a <= s[1];
        b <= s[1] ^ s[0];
        repeat (3) @(posedge clock);
    endtask : step

    task zset(input logic v);
        @(posedge clock);
        z <= v;
    endtask : zset

    // return to the 00 state so a reset never sees a stale pin level as an edge
    task park();
        while (s != 2'h0) step(1'b1);
        zset(1'b0);
    endtask : park
endmodule : cldm_enc
`default_nettype wire

// ==== bench/closed_loop_deviation_monitor_tb_top.sv ====
// self-checking testbench for the closed-loop deviation monitor
`timescale 1ns/100ps
`default_nettype none
module closed_loop_deviation_monitor_tb_top;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, homing_done;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        int_a, int_b, int_z, ext_a, ext_b, ext_z, probe_z, div_out_inhibit;
    logic        deviation_excess_fault, closed_loop_fault, soft_stop, errv;
    logic        forward_overtravel_warning, reverse_overtravel_warning;
    logic [7:0]  ra [9];
    logic [31:0] rv [9];
    int          miscompares, comparisons;

    cldm_top u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .int_a(int_a), .int_b(int_b), .int_z(int_z), .ext_a(ext_a), .ext_b(ext_b),
        .ext_z(ext_z), .homing_done(homing_done), .probe_z(probe_z),
        .div_out_inhibit(div_out_inhibit), .deviation_excess_fault(deviation_excess_fault),
        .closed_loop_fault(closed_loop_fault),
        .forward_overtravel_warning(forward_overtravel_warning),
        .reverse_overtravel_warning(reverse_overtravel_warning), .soft_stop(soft_stop));
    cldm_enc u_int (.clock(clock), .a(int_a), .b(int_b), .z(int_z));
    cldm_enc u_ext (.clock(clock), .a(ext_a), .b(ext_b), .z(ext_z));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // setup, access, then hold until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rdv);
    endtask : rdchk

    task settle();
        repeat (8) @(posedge clock);
    endtask : settle

    task isteps(input int n, input logic up);
        repeat (n) u_int.step(up);
    endtask : isteps

    task esteps(input int n, input logic up);
        repeat (n) u_ext.step(up);
    endtask : esteps

    task do_reset();
        u_int.park();
        u_ext.park();
        rst <= 1'b1;
        homing_done <= 1'b0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
    endtask : do_reset

    // f is {z source, z hide, external invert}
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] f,
                                        input logic [1:0] sm, input logic [1:0] dv,
                                        input logic [3:0] k);
        ctl = (32'(m) << cldm_pkg::C_MODE) | (32'(f) << cldm_pkg::C_INV)
            | (32'(sm) << cldm_pkg::C_SOFT) | (32'(dv) << cldm_pkg::C_DIV)
            | (32'(k) << cldm_pkg::C_FILT);
    endfunction : ctl

    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, homing_done} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        miscompares = 0;
        comparisons = 0;
        ra = '{cldm_pkg::OFS_CTRL, cldm_pkg::OFS_EPPR, cldm_pkg::OFS_LIMIT, cldm_pkg::OFS_CREV,
               cldm_pkg::OFS_IPPR, cldm_pkg::OFS_INUM, cldm_pkg::OFS_ODEN, cldm_pkg::OFS_FWD,
               cldm_pkg::OFS_REV};
        rv = '{cldm_pkg::RST_CTRL, cldm_pkg::RST_EPPR, cldm_pkg::RST_LIMIT, cldm_pkg::RST_CREV,
               cldm_pkg::RST_IPPR, cldm_pkg::RST_GEAR, cldm_pkg::RST_GEAR, cldm_pkg::RST_FWD,
               cldm_pkg::RST_REV};
        do_reset();
        for (int i = 0; i < 9; i++) rdchk("reset value", ra[i], rv[i]);
        rdchk("unmapped read", 8'h3c, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, errv});
        wr(cldm_pkg::OFS_ICNT, 32'h5);
        esteps(3, 1'b1);
        isteps(2, 1'b1);
        rdchk("internal count", cldm_pkg::OFS_ICNT, 32'h2);
        rdchk("external count", cldm_pkg::OFS_ECNT, 32'h3);
        wr(cldm_pkg::OFS_CTRL, ctl(2'h0, 3'h1, 2'h0, 2'h0, 4'h0));
        esteps(3, 1'b1);
        rdchk("inverted up", cldm_pkg::OFS_ECNT, 32'h0);
        esteps(1, 1'b0);
        rdchk("inverted down", cldm_pkg::OFS_ECNT, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(cldm_pkg::OFS_CTRL, ctl(2'h0, 3'h0, 2'h0, 2'(i), 4'h0));
            settle();
            chk("divider inhibit", {31'h0, i == 2}, {31'h0, div_out_inhibit});
        end
        u_int.zset(1'b1);
        wr(cldm_pkg::OFS_CTRL, ctl(2'h1, 3'h0, 2'h0, 2'h0, 4'h0));
        settle();
        chk("inner z", 32'h1, {31'h0, probe_z});
        wr(cldm_pkg::OFS_CTRL, ctl(2'h1, 3'h4, 2'h0, 2'h0, 4'h0));
        settle();
        chk("outer z low", 32'h0, {31'h0, probe_z});
        u_ext.zset(1'b1);
        settle();
        chk("outer z high", 32'h1, {31'h0, probe_z});
        wr(cldm_pkg::OFS_CTRL, ctl(2'h1, 3'h6, 2'h0, 2'h0, 4'h0));
        settle();
        chk("hidden z", 32'h0, {31'h0, probe_z});
        // limit kept well below ppr times clear revolutions
        do_reset();
        wr(cldm_pkg::OFS_LIMIT, 32'h3);
        wr(cldm_pkg::OFS_CTRL, ctl(2'h1, 3'h0, 2'h0, 2'h0, 4'h1));
        isteps(4, 1'b1);
        settle();
        rdchk("filtered dev", cldm_pkg::OFS_DEV, 32'h3);
        chk("fault at limit", 32'h0, {31'h0, deviation_excess_fault});
        wr(cldm_pkg::OFS_CTRL, ctl(2'h1, 3'h0, 2'h0, 2'h0, 4'h0));
        settle();
        rdchk("unfiltered dev", cldm_pkg::OFS_DEV, 32'h4);
        chk("fault over limit", 32'h1, {31'h0, deviation_excess_fault});
        wr(cldm_pkg::OFS_LIMIT, 32'h0);
        wr(cldm_pkg::OFS_CTRL, ctl(2'h1, 3'h0, 2'h0, 2'h0, 4'h0) | (32'h1 << cldm_pkg::C_CLR));
        esteps(8, 1'b1);
        settle();
        chk("zero limit", 32'h0, {31'h0, deviation_excess_fault});
        rdchk("signed dev", cldm_pkg::OFS_DEV, 32'hffff_fffc);
        wr(cldm_pkg::OFS_ONUM, 32'h2);
        wr(cldm_pkg::OFS_CTRL, ctl(2'h2, 3'h0, 2'h0, 2'h0, 4'h0));
        isteps(1, 1'b1);
        settle();
        rdchk("outer gear dev", cldm_pkg::OFS_DEV, 32'hffff_fffe);
        // positive ppr on both sides, one revolution per clear
        do_reset();
        wr(cldm_pkg::OFS_IPPR, 32'h8);
        wr(cldm_pkg::OFS_EPPR, 32'h8);
        wr(cldm_pkg::OFS_CREV, 32'h1);
        wr(cldm_pkg::OFS_LIMIT, 32'h0);
        wr(cldm_pkg::OFS_CTRL, ctl(2'h1, 3'h0, 2'h0, 2'h0, 4'h0));
        isteps(7, 1'b1);
        rdchk("before clear", cldm_pkg::OFS_DEV, 32'h7);
        isteps(1, 1'b1);
        rdchk("after clear", cldm_pkg::OFS_DEV, 32'h0);
        wr(cldm_pkg::OFS_CREV, 32'h0);
        isteps(8, 1'b1);
        rdchk("no clear", cldm_pkg::OFS_DEV, 32'h8);
        do_reset();
        wr(cldm_pkg::OFS_LIMIT, 32'h0);
        wr(cldm_pkg::OFS_CTRL, ctl(2'h1, 3'h0, 2'h0, 2'h0, 4'h0));
        isteps(1023, 1'b1);
        settle();
        chk("stall below", 32'h0, {31'h0, closed_loop_fault});
        isteps(1, 1'b1);
        settle();
        chk("stall fault", 32'h1, {31'h0, closed_loop_fault});
        do_reset();
        wr(cldm_pkg::OFS_FWD, 32'h2);
        wr(cldm_pkg::OFS_REV, 32'hffff_fffe);
        wr(cldm_pkg::OFS_CTRL, ctl(2'h0, 3'h0, 2'h2, 2'h0, 4'h0));
        isteps(3, 1'b1);
        settle();
        chk("unhomed", 32'h0, {31'h0, forward_overtravel_warning});
        homing_done <= 1'b1;
        @(posedge clock);
        homing_done <= 1'b0;
        settle();
        chk("homed fwd", 32'h1, {31'h0, forward_overtravel_warning});
        chk("stop fwd", 32'h1, {31'h0, soft_stop});
        wr(cldm_pkg::OFS_CTRL, ctl(2'h0, 3'h0, 2'h0, 2'h0, 4'h0));
        settle();
        chk("mode off", 32'h0, {31'h0, soft_stop});
        wr(cldm_pkg::OFS_CTRL, ctl(2'h0, 3'h0, 2'h1, 2'h0, 4'h0));
        isteps(1, 1'b0);
        settle();
        chk("fwd at limit", 32'h0, {31'h0, forward_overtravel_warning});
        isteps(5, 1'b0);
        settle();
        chk("rev below", 32'h1, {31'h0, reverse_overtravel_warning});
        chk("stop rev", 32'h1, {31'h0, soft_stop});
        final_report();
    end
endmodule : closed_loop_deviation_monitor_tb_top
`default_nettype wire
